// File: rtl/sdc_pkg.sv
package sdc_pkg;
    // system clock and serial line timing
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned BAUD         = 4800;
    localparam int unsigned BIT_CYC      = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC     = BIT_CYC / 2;
    localparam int unsigned CNT_W        = 12;
    localparam int unsigned FRAME_BITS   = 8;      // 7 data + odd parity
    localparam int unsigned UP_LIMIT_MS  = 100;    // latest re-enable after last byte
    localparam int unsigned UP_GAP_US    = 5000;   // quiet time actually waited
    localparam int unsigned UP_GAP_DEF   = UP_GAP_US * (CLK_HZ / 1_000_000);
    localparam int unsigned GAP_W        = 17;

    // characters and numbering
    localparam logic [6:0] CHR_ENQ = 7'h05;
    localparam logic [6:0] NUM_MIN = 7'h01;
    localparam logic [6:0] NUM_MAX = 7'h59;        // 89

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_NUM  = 8'h08;
    localparam logic [7:0] OFS_DEG  = 8'h0C;
    localparam logic [7:0] OFS_RXC  = 8'h10;

    // status write-one-to-clear bits
    localparam int unsigned ST_ENQ  = 4;
    localparam int unsigned ST_PERR = 5;

    // dispense modes
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_COPY = 2'h1;
    localparam logic [1:0] MODE_VOL  = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic       ad_en;
        logic       own_rts;
        logic       up_req;
        logic       down_req;
    } sdc_ctrl_t;

    localparam sdc_ctrl_t CTRL_RST = '{mode: MODE_CONT, ad_en: 1'b0, own_rts: 1'b1,
                                       up_req: 1'b1, down_req: 1'b1};
    localparam logic [7:0] DEG_RST = 8'h0F;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sdc_apb_req_t;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sdc_rx_st_t;
    typedef enum logic [0:0] {AD_IDLE, AD_REV} sdc_ad_st_t;
endpackage

// File: rtl/sdc_uart_rx.sv
module sdc_uart_rx
    import sdc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       line_i,
    output logic            busy_o,
    output logic            valid_o,
    output logic [6:0]      data_o,
    output logic            perr_o
);
    typedef struct packed {
        sdc_rx_st_t       st;
        logic [CNT_W-1:0] cnt;
        logic [3:0]       nbit;
        logic [7:0]       sh;
        logic             valid;
        logic [6:0]       data;
        logic             perr;
    } sdc_rx_s_t;

    sdc_rx_s_t s_ff;
    sdc_rx_s_t nxt_s;

    always_comb begin
        nxt_s       = s_ff;
        nxt_s.valid = 1'b0;
        nxt_s.cnt   = s_ff.cnt + 1'b1;
        case (s_ff.st)
            RX_IDLE: begin
                nxt_s.cnt = '0;
                if (!line_i) begin
                    nxt_s.st = RX_START;
                end
            end
            RX_START: begin
                // a glitch shorter than half a bit is not a start bit
                if (s_ff.cnt == CNT_W'(HALF_CYC)) begin
                    nxt_s.cnt  = '0;
                    nxt_s.nbit = '0;
                    nxt_s.st   = line_i ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (s_ff.cnt == CNT_W'(BIT_CYC - 1)) begin
                    nxt_s.cnt  = '0;
                    nxt_s.sh   = {line_i, s_ff.sh[7:1]};
                    nxt_s.nbit = s_ff.nbit + 1'b1;
                    if (s_ff.nbit == 4'(FRAME_BITS - 1)) begin
                        nxt_s.st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (s_ff.cnt == CNT_W'(BIT_CYC - 1)) begin
                    nxt_s.st    = RX_IDLE;
                    nxt_s.valid = 1'b1;
                    nxt_s.data  = s_ff.sh[6:0];
                    nxt_s.perr  = !(^s_ff.sh) || !line_i;
                end
            end
            default: nxt_s.st = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '{st: RX_IDLE, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy_o  = (s_ff.st != RX_IDLE);
    assign valid_o = s_ff.valid;
    assign data_o  = s_ff.data;
    assign perr_o  = s_ff.perr;
endmodule // sdc_uart_rx

// File: rtl/sdc_antidrip.sv
module sdc_antidrip
    import sdc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       en_i,
    input  wire logic [1:0] mode_i,
    input  wire logic [7:0] deg_i,
    input  wire logic       dispense_done_i,
    input  wire logic       deg_tick_i,
    output logic            reverse_o
);
    typedef struct packed {
        sdc_ad_st_t st;
        logic [7:0] left;
        logic       rev;
    } sdc_ad_s_t;

    sdc_ad_s_t s_ff;
    sdc_ad_s_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        case (s_ff.st)
            AD_IDLE: begin
                if (dispense_done_i && en_i && (mode_i == MODE_COPY || mode_i == MODE_VOL)
                    && deg_i != '0) begin
                    nxt_s.st   = AD_REV;
                    nxt_s.left = deg_i;
                    nxt_s.rev  = 1'b1;
                end
            end
            AD_REV: begin
                if (deg_tick_i) begin
                    nxt_s.left = s_ff.left - 1'b1;
                    if (s_ff.left == 8'h01) begin
                        nxt_s.st  = AD_IDLE;
                        nxt_s.rev = 1'b0;
                    end
                end
            end
            default: nxt_s.st = AD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= '{st: AD_IDLE, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign reverse_o = s_ff.rev;
endmodule // sdc_antidrip

// File: rtl/sdc_gate.sv
module sdc_gate
    import sdc_pkg::*;
#(
    parameter int unsigned UP_GAP_CYC = UP_GAP_DEF
) (
    input  wire logic        ref_clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_txd_i,
    output logic             down_txd_o,
    input  wire logic        down_rxd_i,
    output logic             up_rxd_o,
    input  wire logic        down_rts_i,
    output logic             up_rts_o,
    input  wire logic        own_txd_i,
    input  wire logic        dispense_done_i,
    input  wire logic        deg_tick_i,
    output logic             reverse_o
);
    typedef struct packed {
        sdc_ctrl_t          ctrl;
        logic               down_app;
        logic               up_app;
        logic [6:0]         num;
        logic [7:0]         deg;
        logic               enq_seen;
        logic               perr_seen;
        logic [6:0]         rxchar;
        logic               up_pend;
        logic [GAP_W-1:0]   gap;
        logic               in_host;
        logic               in_down;
        logic               in_rts;
        logic               in_own;
        logic               down_txd;
        logic               up_rxd;
        logic               up_rts;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } sdc_state_t;

    localparam sdc_state_t STATE_RST = '{ctrl: CTRL_RST, down_app: 1'b1, up_app: 1'b1,
                                         deg: DEG_RST, down_txd: 1'b1, up_rxd: 1'b1,
                                         up_rts: 1'b1, in_host: 1'b1, in_down: 1'b1,
                                         in_own: 1'b1, default: '0};

    sdc_state_t   s_ff;
    sdc_state_t   nxt_s;
    sdc_apb_req_t req;

    logic       host_busy;
    logic       host_valid;
    logic [6:0] host_data;
    logic       host_perr;
    logic       down_busy;
    logic       own_busy;

    function automatic logic num_ok(input logic [31:0] v);
        return (v[31:7] == '0) && (v[6:0] >= NUM_MIN) && (v[6:0] <= NUM_MAX);
    endfunction

    function automatic logic known_ofs(input logic [7:0] a);
        return a == OFS_CTRL || a == OFS_STAT || a == OFS_NUM || a == OFS_DEG || a == OFS_RXC;
    endfunction

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // host line is decoded for enquiries and also marks where frames begin and end
    sdc_uart_rx u_host_rx (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .line_i    (host_txd_i),
        .busy_o    (host_busy),
        .valid_o   (host_valid),
        .data_o    (host_data),
        .perr_o    (host_perr)
    );

    sdc_uart_rx u_down_mon (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .line_i    (down_rxd_i),
        .busy_o    (down_busy),
        .valid_o   (),
        .data_o    (),
        .perr_o    ()
    );

    sdc_uart_rx u_own_mon (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .line_i    (own_txd_i),
        .busy_o    (own_busy),
        .valid_o   (),
        .data_o    (),
        .perr_o    ()
    );

    sdc_antidrip u_antidrip (
        .ref_clk_i       (ref_clk_i),
        .arst_n_i        (arst_n_i),
        .en_i            (s_ff.ctrl.ad_en),
        .mode_i          (s_ff.ctrl.mode),
        .deg_i           (s_ff.deg),
        .dispense_done_i (dispense_done_i),
        .deg_tick_i      (deg_tick_i),
        .reverse_o       (reverse_o)
    );

    always_comb begin
        logic wr;
        logic [31:0] st_word;
        wr      = req.psel && req.penable && s_ff.pready && req.pwrite && !s_ff.pslverr;
        st_word = {26'h0, s_ff.perr_seen, s_ff.enq_seen, reverse_o,
                   s_ff.up_rts, s_ff.up_app, s_ff.down_app};
        nxt_s = s_ff;

        // register writes
        if (wr) begin
            case (req.paddr)
                OFS_CTRL: nxt_s.ctrl = sdc_ctrl_t'(req.pwdata[$bits(sdc_ctrl_t)-1:0]);
                OFS_STAT: begin
                    if (req.pwdata[ST_ENQ]) begin
                        nxt_s.enq_seen = 1'b0;
                    end
                    if (req.pwdata[ST_PERR]) begin
                        nxt_s.perr_seen = 1'b0;
                    end
                end
                OFS_NUM: begin
                    nxt_s.num           = req.pwdata[6:0];
                    nxt_s.ctrl.own_rts  = 1'b0;
                    nxt_s.ctrl.down_req = 1'b1;
                    nxt_s.up_pend       = 1'b1;
                    nxt_s.gap           = '0;
                end
                OFS_DEG:  nxt_s.deg = req.pwdata[7:0];
                default:  nxt_s.deg = s_ff.deg;
            endcase
        end

        // incoming characters; hardware set wins over a clear in the same cycle
        if (host_valid) begin
            nxt_s.rxchar = host_data;
            if (host_perr) begin
                nxt_s.perr_seen = 1'b1;
            end else if (host_data == CHR_ENQ) begin
                nxt_s.enq_seen = 1'b1;
                if (s_ff.ctrl.own_rts) begin
                    nxt_s.ctrl.down_req = 1'b0;
                    nxt_s.ctrl.up_req   = 1'b0;
                    nxt_s.up_pend       = 1'b0;
                end
            end
        end

        // upstream path returns once the own transmitter has been quiet long enough
        if (s_ff.up_pend) begin
            if (own_busy) begin
                nxt_s.gap = '0;
            end else if (s_ff.gap == GAP_W'(UP_GAP_CYC - 1)) begin
                nxt_s.up_pend     = 1'b0;
                nxt_s.ctrl.up_req = 1'b1;
            end else begin
                nxt_s.gap = s_ff.gap + 1'b1;
            end
        end

        // applied gates follow the requests only while their lines are idle
        if (!host_busy) begin
            nxt_s.down_app = s_ff.ctrl.down_req;
        end
        if (!down_busy && !own_busy) begin
            nxt_s.up_app = s_ff.ctrl.up_req;
        end

        // one input stage per line and one gate per driver; host, down and own pins also feed a receiver, so only the rts pin sees a single load
        nxt_s.in_host  = host_txd_i;
        nxt_s.in_down  = down_rxd_i;
        nxt_s.in_rts   = down_rts_i;
        nxt_s.in_own   = own_txd_i;
        nxt_s.down_txd = s_ff.in_host | !s_ff.down_app;
        nxt_s.up_rxd   = s_ff.in_own & (s_ff.in_down | !s_ff.up_app);
        nxt_s.up_rts   = s_ff.ctrl.own_rts | (s_ff.in_rts & s_ff.up_app);

        // apb: answer is prepared in the setup cycle, so every access has no wait state
        nxt_s.pready = req.psel && !req.penable;
        if (req.psel && !req.penable) begin
            nxt_s.pslverr = !known_ofs(req.paddr)
                            || (req.pwrite && req.paddr == OFS_NUM && !num_ok(req.pwdata));
            case (req.paddr)
                OFS_CTRL: nxt_s.prdata = 32'(s_ff.ctrl);
                OFS_STAT: nxt_s.prdata = st_word;
                OFS_NUM:  nxt_s.prdata = {25'h0, s_ff.num};
                OFS_DEG:  nxt_s.prdata = {24'h0, s_ff.deg};
                OFS_RXC:  nxt_s.prdata = {25'h0, s_ff.rxchar};
                default:  nxt_s.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_ff <= STATE_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign down_txd_o = s_ff.down_txd;
    assign up_rxd_o   = s_ff.up_rxd;
    assign up_rts_o   = s_ff.up_rts;
    assign prdata     = s_ff.prdata;
    assign pready     = s_ff.pready;
    assign pslverr    = s_ff.pslverr;
endmodule // sdc_gate

// File: tb/sdc_checker.sv
module sdc_checker
    import sdc_pkg::*;
#(
    parameter int unsigned UP_GAP_CYC = UP_GAP_DEF
) (
    input wire logic        ref_clk_i,
    input wire logic        arst_n_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        host_txd_i,
    input wire logic        down_txd_o,
    input wire logic        down_rxd_i,
    input wire logic        up_rxd_o,
    input wire logic        up_rts_o,
    input wire logic        own_txd_i,
    input wire logic        dispense_done_i,
    input wire logic        deg_tick_i,
    input wire logic        reverse_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    relay_down_a: assert property (!down_txd_o |-> !$past(host_txd_i, 2))
        else $error("down line low without host low");
    // a low output after a low one means the gate was open mid frame and must stay so
    gate_hold_a: assert property (!$past(down_txd_o) && !$past(host_txd_i, 2) |-> !down_txd_o)
        else $error("down gate moved mid frame");
    own_tx_a: assert property (!$past(own_txd_i, 2) |-> !up_rxd_o)
        else $error("own transmitter missing upstream");
    up_relay_a: assert property (!up_rxd_o |-> !$past(own_txd_i, 2) || !$past(down_rxd_i, 2))
        else $error("up line low without cause");
    reset_idle_a: assert property ($rose(arst_n_i) |-> up_rts_o && down_txd_o && up_rxd_o)
        else $error("lines not idle after reset");
    rev_start_a: assert property ($rose(reverse_o) |-> $past(dispense_done_i))
        else $error("reverse without dispense");
    rev_stop_a: assert property ($fell(reverse_o) |-> $past(deg_tick_i) || $past(deg_tick_i, 2))
        else $error("reverse ended without tick");
    apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not one access cycle");
    unmapped_err_a: assert property (psel && penable && paddr > OFS_RXC |-> pslverr)
        else $error("unmapped access not refused");
    num_range_a: assert property (psel && penable && pwrite && paddr == OFS_NUM &&
        (pwdata == 32'h0 || pwdata > {25'h0, NUM_MAX}) |-> pslverr)
        else $error("bad number accepted");
endmodule // sdc_checker

bind sdc_gate sdc_checker #(.UP_GAP_CYC(UP_GAP_CYC)) chk_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .host_txd_i(host_txd_i),
    .down_txd_o(down_txd_o), .down_rxd_i(down_rxd_i), .up_rxd_o(up_rxd_o), .up_rts_o(up_rts_o),
    .own_txd_i(own_txd_i), .dispense_done_i(dispense_done_i), .deg_tick_i(deg_tick_i),
    .reverse_o(reverse_o)
);

// File: tb/sdc_far_model.sv
module sdc_far_model
    import sdc_pkg::*;
(
    input  wire logic ref_clk_i,
    output logic      host_txd_o,
    output logic      down_rxd_o,
    output logic      down_rts_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        host_txd_o = 1'b1;
        down_rxd_o = 1'b1;
        down_rts_o = 1'b0;
    end

    // the computer line rests high between frames, as an idle serial line does
    task automatic send_host(input logic [6:0] ch, input logic bad);
        logic [9:0] fr;
        fr = {1'b1, (~^ch) ^ bad, ch, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_txd_o <= fr[i];
            repeat (BIT_CYC) @(posedge ref_clk_i);
        end
    endtask

    task automatic set_down(input logic rxd, input logic rts);
        down_rxd_o <= rxd;
        down_rts_o <= rts;
    endtask
endmodule // sdc_far_model

// File: tb/tb_serial_daisy_chain_gating.sv
module tb_serial_daisy_chain_gating
    import sdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned GAP = 200;
    logic        ref_clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, er;
    logic        host_txd, down_rxd, down_rts, own_txd_i, dispense_done_i, deg_tick_i;
    logic        down_txd_o, up_rxd_o, up_rts_o, reverse_o;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] badn [3] = '{32'h0, 32'h5A, 32'h81};
    logic [8:0]  hist;
    logic [9:0]  ef;
    logic [2:0]  r;
    int          compares = 0, fails = 0, lows;

    sdc_gate #(.UP_GAP_CYC(GAP)) dut (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .host_txd_i(host_txd), .down_txd_o(down_txd_o), .down_rxd_i(down_rxd), .up_rxd_o(up_rxd_o),
        .down_rts_i(down_rts), .up_rts_o(up_rts_o), .own_txd_i(own_txd_i),
        .dispense_done_i(dispense_done_i), .deg_tick_i(deg_tick_i), .reverse_o(reverse_o));
    sdc_far_model far (.ref_clk_i(ref_clk_i), .host_txd_o(host_txd), .down_rxd_o(down_rxd),
        .down_rts_o(down_rts));

    initial ref_clk_i = 1'b0;
    always #50 ref_clk_i = ~ref_clk_i;

    function automatic logic [9:0] exp_frame(input logic [6:0] c);
        return {1'b1, ~^c, c, 1'b0};
    endfunction

    function automatic logic exp_rev(input logic [1:0] m);
        return m == MODE_COPY || m == MODE_VOL;
    endfunction

    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s exp %0h got %0h", what, exp, got);
        end
    endtask

    // pready is read at the rising edge, before that edge's register updates land
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge ref_clk_i);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        if (n >= 20) begin
            fails++;
            test_done();
        end
    endtask

    initial begin
        void'($urandom(76694));
        arst_n_i = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {own_txd_i, dispense_done_i, deg_tick_i} = 3'h4;
        repeat (8) @(posedge ref_clk_i);
        chk("reset pins", 32'h7, {29'h0, up_rts_o, down_txd_o, up_rxd_o});
        arst_n_i <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl", 32'h07, rd);
        apb(1'b0, OFS_DEG, 32'h0);
        chk("deg", 32'h0F, rd);
        apb(1'b1, 8'h14, 32'hFFFFFFFF);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped rd", 32'h0, rd);
        apb(1'b1, OFS_CTRL, 32'h06);
        lows = 0;
        fork
            far.send_host(7'($urandom), 1'b1);
            repeat (10 * BIT_CYC) begin
                @(negedge ref_clk_i);
                lows += !down_txd_o;
            end
        join
        chk("blocked lows", 32'(lows), 32'h0);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("parity flag", 32'h1, {31'h0, rd[ST_PERR]});
        apb(1'b1, OFS_STAT, 32'h20);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("parity clear", 32'h0, {31'h0, rd[ST_PERR]});
        r = 3'h5;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, OFS_CTRL, p ? 32'h03 : 32'h07);
            repeat (2) @(posedge ref_clk_i);
            hist = {3{r}};
            repeat (200) begin
                @(posedge ref_clk_i);
                r = 3'($urandom);
                far.set_down(r[0], r[1]);
                own_txd_i <= r[2];
                hist = {hist[5:0], r};
                @(negedge ref_clk_i);
                chk("up_rxd_o", {31'h0, hist[8] & hist[6]}, {31'h0, up_rxd_o});
                chk("up_rts_o", {31'h0, (p == 0) | hist[7]}, {31'h0, up_rts_o});
            end
        end
        @(posedge ref_clk_i);
        far.set_down(1'b1, 1'b1);
        own_txd_i <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h07);
        ef = exp_frame(CHR_ENQ);
        fork
            far.send_host(CHR_ENQ, 1'b0);
            begin
                repeat (HALF_CYC + 2) @(posedge ref_clk_i);
                for (int i = 0; i < 10; i++) begin
                    @(negedge ref_clk_i);
                    chk("down_txd_o", {31'h0, ef[i]}, {31'h0, down_txd_o});
                    repeat (BIT_CYC - 1) @(posedge ref_clk_i);
                end
            end
        join
        repeat (10) @(posedge ref_clk_i);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl after enq", 32'h04, rd);
        apb(1'b0, OFS_RXC, 32'h0);
        chk("rxchar", {25'h0, CHR_ENQ}, rd);
        foreach (badn[i]) begin
            apb(1'b1, OFS_NUM, badn[i]);
            chk("num refused", 32'h1, {31'h0, er});
        end
        apb(1'b1, OFS_NUM, {25'h0, NUM_MAX});
        chk("num taken", 32'h0, {31'h0, er});
        repeat (100) @(posedge ref_clk_i);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl numbered", 32'h01, rd);
        @(negedge ref_clk_i);
        chk("up_rts_o held", 32'h0, {31'h0, up_rts_o});
        repeat (GAP) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("up_rts_o reopened", 32'h1, {31'h0, up_rts_o});
        apb(1'b0, OFS_NUM, 32'h0);
        chk("num", {25'h0, NUM_MAX}, rd);
        apb(1'b1, OFS_DEG, 32'h03);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, OFS_CTRL, {26'h0, 2'(m), 4'hB});
            @(posedge ref_clk_i);
            dispense_done_i <= 1'b1;
            @(posedge ref_clk_i);
            dispense_done_i <= 1'b0;
            for (int t = 0; t < 4; t++) begin
                @(posedge ref_clk_i);
                @(negedge ref_clk_i);
                chk("reverse_o", {31'h0, exp_rev(2'(m)) && t < 3}, {31'h0, reverse_o});
                @(posedge ref_clk_i);
                deg_tick_i <= (t < 3);
                @(posedge ref_clk_i);
                deg_tick_i <= 1'b0;
            end
        end
        test_done();
    end
endmodule // tb_serial_daisy_chain_gating
